// [core/ies_syndrome.sv]
// Local design decisions: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
module ies_syndrome
  import ies_pkg::*;
(
  input  wire logic           core_clk,
  input  wire logic           rst_n,
  input  wire logic           ce,
  input  wire ies_addr_evt_s  redist_read_corrupt,
  input  wire ies_addr_evt_s  dist_read_corrupt,
  input  wire ies_addr_evt_s  translator_powered_off,
  input  wire ies_id_evt_s    shared_block_missing,
  input  wire ies_id_evt_s    shared_id_out_of_range,
  input  wire ies_id_evt_s    shared_no_target,
  input  wire ies_id_evt_s    one_of_n_undeliverable,
  input  wire ies_id_evt_s    collator_out_of_range,
  input  wire ies_deact_evt_s bad_deactivate,
  input  wire ies_virtual_software_interrupt_evt_s  virtual_sgi_fault,
  input  wire ies_vpe_evt_s   virtual_pending_read_fail,
  input  wire logic [7:0]     reg_addr,
  input  wire logic [31:0]    reg_wdata,
  input  wire logic           reg_wr,
  input  wire logic           reg_rd,
  output logic [31:0]         reg_rdata,
  output logic                irq,
  output logic                rec_valid
);

  // ------------------------------------------------------------
  // Misc data packing helpers
  // ------------------------------------------------------------

  // Interrupt ID in the low ten bits, upper bits zero
  function automatic logic [31:0] misc_id(input logic [9:0] id);
    misc_id = {22'h00_0000, id};
  endfunction

  // Virtual processor number in the low bits, upper bits zero
  function automatic logic [31:0] misc_vpe(input logic [`IES_VPE_W-1:0] vpe);
    misc_vpe = {23'h00_0000, vpe};
  endfunction

  // ------------------------------------------------------------
  // Storage
  // ------------------------------------------------------------
  ies_rec_s              rec_q;        // Captured error record
  logic                  rec_valid_q;  // Record holds an unread error
  logic                  rec_ovf_q;    // An error was lost
  logic [1:0]            stat_q;       // Sticky interrupt causes
  logic [1:0]            en_q;         // Interrupt enables
  logic [31:0]           rdata_q;      // Read data, one cycle late
  logic                  irq_q;        // Interrupt level

  // ------------------------------------------------------------
  // Detection
  // ------------------------------------------------------------
  logic [`IES_NSRC-1:0]  hit_vec;      // One bit per reporting source
  logic                  deact_report; // Deactivate worth reporting
  logic                  hit;          // Some source reports now
  logic                  multi;        // More than one source at once
  ies_rec_s              cand;         // Record of winning source
  logic                  load;         // Record takes the candidate
  logic                  clr_valid;    // Software releases the record
  logic                  clr_ovf;      // Software clears overflow
  logic                  ovf_set;      // A report is being dropped
  logic [1:0]            stat_clr;     // Interrupt causes to clear

  // Only shared-interrupt deactivates count; the others pass silently
  assign deact_report = bad_deactivate.valid &&
                        (bad_deactivate.kind == IES_DEACT_SHARED_MISSING ||
                         bad_deactivate.kind == IES_DEACT_SHARED_GROUP); // RL12

  // Bit order is also the priority order, lowest index first
  assign hit_vec = {virtual_pending_read_fail.valid,
                    virtual_sgi_fault.valid && virtual_sgi_fault.kind != 2'b11,
                    deact_report,
                    collator_out_of_range.valid,
                    one_of_n_undeliverable.valid,
                    shared_no_target.valid,
                    shared_id_out_of_range.valid,
                    shared_block_missing.valid,
                    translator_powered_off.valid,
                    dist_read_corrupt.valid,
                    redist_read_corrupt.valid};
  assign hit   = |hit_vec;
  assign multi = $countones(hit_vec) > 1;

  // Pick the highest-priority source and build its full record
  always_comb
  begin
    cand = '0;
    if (redist_read_corrupt.valid)
    begin
      cand.syn  = `IES_SYN_REDIST; // RL1
      cand.error_type_code = `IES_ERROR_TYPE_CODE_CORRUPT;
      cand.addr = redist_read_corrupt.addr;
    end
    else if (dist_read_corrupt.valid)
    begin
      cand.syn  = `IES_SYN_DIST; // RL2
      cand.error_type_code = `IES_ERROR_TYPE_CODE_CORRUPT;
      cand.addr = dist_read_corrupt.addr;
    end
    else if (translator_powered_off.valid)
    begin
      // A read while the translator's power channel is not running
      cand.syn  = `IES_SYN_TRANS_OFF; // RL3
      cand.error_type_code = `IES_ERROR_TYPE_CODE_STATE;
      cand.addr = translator_powered_off.addr;
    end
    else if (shared_block_missing.valid)
    begin
      cand.syn  = `IES_SYN_BLOCK; // RL5
      cand.error_type_code = `IES_ERROR_TYPE_CODE_ILLEGAL;
      cand.misc = {27'h000_0000, shared_block_missing.id[4:0]}; // RL17
    end
    else if (shared_id_out_of_range.valid)
    begin
      cand.syn  = `IES_SYN_ID_OOR; // RL6
      cand.error_type_code = `IES_ERROR_TYPE_CODE_ILLEGAL;
      cand.misc = misc_id(shared_id_out_of_range.id);
    end
    else if (shared_no_target.valid)
    begin
      cand.syn  = `IES_SYN_NO_TARGET; // RL7
      cand.error_type_code = `IES_ERROR_TYPE_CODE_STATE;
      cand.misc = misc_id(shared_no_target.id);
    end
    else if (one_of_n_undeliverable.valid)
    begin
      cand.syn  = `IES_SYN_ONE_OF_N; // RL8
      cand.error_type_code = `IES_ERROR_TYPE_CODE_STATE;
      cand.misc = misc_id(one_of_n_undeliverable.id);
    end
    else if (collator_out_of_range.valid)
    begin
      cand.syn  = `IES_SYN_COLLATOR; // RL10
      cand.error_type_code = `IES_ERROR_TYPE_CODE_STATE;
      cand.misc = misc_id(collator_out_of_range.id);
    end
    else if (deact_report)
    begin
      // No misc data for a deactivate, misc stays zero
      cand.syn  = `IES_SYN_DEACT; // RL11
      cand.error_type_code = `IES_ERROR_TYPE_CODE_ILLEGAL;
    end
    else if (hit_vec[9])
    begin
      cand.error_type_code = `IES_ERROR_TYPE_CODE_STATE;
      unique case (virtual_sgi_fault.kind)
        IES_VIRTUAL_SOFTWARE_INTERRUPT_OFFLINE:
        begin
          // Chip lowest, then vector, then processor number
          cand.syn  = `IES_SYN_VIRTUAL_SOFTWARE_INTERRUPT_OFF; // RL13
          cand.misc = {3'h0, virtual_sgi_fault.vpe, virtual_sgi_fault.vector,
                       virtual_sgi_fault.chip}; // RL17
        end
        IES_VIRTUAL_SOFTWARE_INTERRUPT_UNMAPPED:
        begin
          cand.syn  = `IES_SYN_VIRTUAL_SOFTWARE_INTERRUPT_UNMAP; // RL14
          cand.misc = {7'h00, virtual_sgi_fault.vpe, virtual_sgi_fault.vector};
        end
        default:
        begin
          cand.syn  = `IES_SYN_VIRTUAL_SOFTWARE_INTERRUPT_INCON; // RL15
          cand.misc = {7'h00, virtual_sgi_fault.vpe, virtual_sgi_fault.vector};
        end
      endcase
    end
    else if (virtual_pending_read_fail.valid)
    begin
      cand.syn  = `IES_SYN_VPT_READ; // RL16
      cand.error_type_code = `IES_ERROR_TYPE_CODE_MEMRESP;
      cand.misc = misc_vpe(virtual_pending_read_fail.vpe);
    end
  end

  // ------------------------------------------------------------
  // Register writes
  // ------------------------------------------------------------
  assign clr_valid = reg_wr && reg_addr == `IES_OFS_REC &&
                     reg_wdata[`IES_REC_VALID_BIT];
  assign clr_ovf   = reg_wr && reg_addr == `IES_OFS_REC &&
                     reg_wdata[`IES_REC_OVF_BIT];
  assign stat_clr  = (reg_wr && reg_addr == `IES_OFS_IRQ_CLR) ? reg_wdata[1:0] : 2'h0;

  // A free record, or one being released this cycle, takes the report
  assign load    = hit && (!rec_valid_q || clr_valid);
  // Reports that find the record busy, or lose the priority pick, are lost
  assign ovf_set = (hit && rec_valid_q && !clr_valid) || multi; // RL9

  // ------------------------------------------------------------
  // Error record
  // ------------------------------------------------------------

  // All fields land together on the detection edge
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      rec_q       <= '0;
      rec_valid_q <= 1'b0;
    end
    else if (ce)
    begin
      if (load)
      begin
        rec_q       <= cand; // RL18
        rec_valid_q <= 1'b1;
      end
      else if (clr_valid)
      begin
        rec_valid_q <= 1'b0;
      end
    end
  end

  // Overflow flag; a new loss beats a clear in the same cycle
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      rec_ovf_q <= 1'b0;
    end
    else if (ce)
    begin
      if (ovf_set)
        rec_ovf_q <= 1'b1; // RL9
      else if (clr_ovf)
        rec_ovf_q <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Interrupt
  // ------------------------------------------------------------

  // Sticky causes: bit 0 record logged, bit 1 overflow; set wins
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      stat_q <= 2'h0;
      en_q   <= 2'h0;
      irq_q  <= 1'b0;
    end
    else if (ce)
    begin
      stat_q[`IES_IRQ_LOG_BIT] <= load ||
                                  (stat_q[`IES_IRQ_LOG_BIT] && !stat_clr[`IES_IRQ_LOG_BIT]);
      stat_q[`IES_IRQ_OVF_BIT] <= ovf_set ||
                                  (stat_q[`IES_IRQ_OVF_BIT] && !stat_clr[`IES_IRQ_OVF_BIT]);
      if (reg_wr && reg_addr == `IES_OFS_IRQ_EN)
        en_q <= reg_wdata[1:0];
      // Registered so the pin is glitch free; lags status by one cycle
      irq_q <= |(stat_q & en_q);
    end
  end

  // ------------------------------------------------------------
  // Register reads
  // ------------------------------------------------------------

  // Data stands only in the cycle after the strobe, zero elsewhere
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      rdata_q <= `IES_ZERO32;
    end
    else if (ce)
    begin
      rdata_q <= `IES_ZERO32;
      if (reg_rd)
      begin
        unique case (reg_addr)
          `IES_OFS_REC:
            rdata_q <= {8'h00, rec_q.syn, rec_q.error_type_code, 6'h00, rec_ovf_q, rec_valid_q};
          `IES_OFS_MISC:     rdata_q <= rec_q.misc;
          `IES_OFS_ADDR:     rdata_q <= rec_q.addr;
          `IES_OFS_IRQ_STAT: rdata_q <= {30'h0000_0000, stat_q};
          `IES_OFS_IRQ_EN:   rdata_q <= {30'h0000_0000, en_q};
          // Clear register is write-only; unmapped reads give zero
          default:           rdata_q <= `IES_ZERO32;
        endcase
      end
    end
  end

  assign reg_rdata = rdata_q;
  assign irq       = irq_q;
  assign rec_valid = rec_valid_q;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  a_redist_record: assert property ( // RL1
    ce && !rec_valid_q && redist_read_corrupt.valid |=>
      rec_q.syn == 8'h12 && rec_q.error_type_code == 8'h06 &&
      rec_q.addr == $past(redist_read_corrupt.addr))
    else $error("redistributor corrupt read not logged");

  a_dist_record: assert property ( // RL2
    ce && !rec_valid_q && hit_vec == 11'h002 |=>
      rec_q.syn == 8'h13 && rec_q.error_type_code == 8'h06 &&
      rec_q.addr == $past(dist_read_corrupt.addr))
    else $error("distributor corrupt read not logged");

  a_trans_record: assert property ( // RL3
    ce && !rec_valid_q && hit_vec == 11'h004 |=>
      rec_q.syn == 8'h14 && rec_q.error_type_code == 8'h0F &&
      rec_q.addr == $past(translator_powered_off.addr))
    else $error("powered-off translator read not logged");

  a_block_misc: assert property ( // RL5
    ce && !rec_valid_q && hit_vec == 11'h008 |=>
      rec_q.syn == 8'h18 && rec_q.error_type_code == 8'h0E &&
      rec_q.misc == {27'h000_0000, $past(shared_block_missing.id[4:0])})
    else $error("missing block record wrong");

  a_oor_misc: assert property ( // RL6
    ce && !rec_valid_q && hit_vec == 11'h010 |=>
      rec_q.syn == 8'h19 && rec_q.error_type_code == 8'h0E &&
      rec_q.misc == {22'h00_0000, $past(shared_id_out_of_range.id)})
    else $error("out-of-range id record wrong");

  a_no_target: assert property ( // RL7
    ce && !rec_valid_q && hit_vec == 11'h020 |=>
      rec_q.syn == 8'h1A && rec_q.error_type_code == 8'h0F &&
      rec_q.misc[9:0] == $past(shared_no_target.id))
    else $error("no-target record wrong");

  a_one_of_n: assert property ( // RL8
    ce && !rec_valid_q && hit_vec == 11'h040 |=>
      rec_q.syn == 8'h1B && rec_q.error_type_code == 8'h0F &&
      rec_q.misc[9:0] == $past(one_of_n_undeliverable.id))
    else $error("one-of-n record wrong");

  a_busy_overflow: assert property ( // RL9
    ce && hit && rec_valid_q && !clr_valid |=>
      rec_ovf_q && $stable(rec_q) ##1 (rec_ovf_q || $past(clr_ovf)))
    else $error("lost report did not set overflow");

  a_collator_rec: assert property ( // RL10
    ce && !rec_valid_q && hit_vec == 11'h080 |=>
      rec_q.syn == 8'h1C && rec_q.error_type_code == 8'h0F &&
      rec_q.misc[9:0] == $past(collator_out_of_range.id))
    else $error("collator record wrong");

  a_deact_record: assert property ( // RL11
    ce && !rec_valid_q && hit_vec == 11'h100 |=>
      rec_q.syn == 8'h1D && rec_q.error_type_code == 8'h0E && rec_q.misc == 32'h0000_0000)
    else $error("deactivate record wrong");

  a_deact_silent: assert property ( // RL12
    ce && !rec_valid_q && bad_deactivate.valid && bad_deactivate.kind[1] &&
      hit_vec[7:0] == 8'h00 && !hit_vec[9] && !hit_vec[10] |=> !rec_valid_q)
    else $error("private or locality deactivate was logged");

  a_virtual_software_interrupt_offline: assert property ( // RL13
    ce && !rec_valid_q && hit_vec == 11'h200 &&
      virtual_sgi_fault.kind == IES_VIRTUAL_SOFTWARE_INTERRUPT_OFFLINE |=>
      rec_q.syn == 8'h25 && rec_q.misc[19:4] == $past(virtual_sgi_fault.vector) &&
      rec_q.misc[3:0] == $past(virtual_sgi_fault.chip))
    else $error("offline virtual sgi record wrong");

  a_virtual_software_interrupt_unmapped: assert property ( // RL14
    ce && !rec_valid_q && hit_vec == 11'h200 &&
      virtual_sgi_fault.kind == IES_VIRTUAL_SOFTWARE_INTERRUPT_UNMAPPED |=>
      rec_q.syn == 8'h30 && rec_q.error_type_code == 8'h0F &&
      rec_q.misc == {7'h00, $past(virtual_sgi_fault.vpe), $past(virtual_sgi_fault.vector)})
    else $error("unmapped virtual sgi record wrong");

  a_virtual_software_interrupt_incon: assert property ( // RL15
    ce && !rec_valid_q && hit_vec == 11'h200 &&
      virtual_sgi_fault.kind == IES_VIRTUAL_SOFTWARE_INTERRUPT_INCONSISTENT |=>
      rec_q.syn == 8'h33 && rec_q.error_type_code == 8'h0F && rec_q.misc[31:25] == 7'h00)
    else $error("inconsistent virtual sgi record wrong");

  a_vpt_read: assert property ( // RL16
    ce && !rec_valid_q && hit_vec == 11'h400 |=>
      rec_q.syn == 8'h34 && rec_q.error_type_code == 8'h12 &&
      rec_q.misc == {23'h00_0000, $past(virtual_pending_read_fail.vpe)})
    else $error("pending table read record wrong");

  a_same_cycle: assert property ( // RL18
    ce && hit && !rec_valid_q |=> rec_valid_q && rec_q == $past(cand) && stat_q[0])
    else $error("record not written in detection cycle");

endmodule

// [inc/ies_consts.svh]
`ifndef IES_CONSTS_SVH
`define IES_CONSTS_SVH
// Functional notes
// RL1: Corrupt redistributor read logs 0x12/0x6 plus address
// RL2: Corrupt distributor read logs 0x13/0x6 plus address
// RL3: Powered-off translator read logs 0x14/0xF plus address
// RL4: Outside party powers translator up before access
// RL5: Missing shared block logs 0x18/0xE, block number
// RL6: Out-of-range shared set/clear logs 0x19, ID
// RL7: Shared interrupt without target logs 0x1A/0xF, ID
// RL8: Undeliverable one-of-N interrupt logs 0x1B/0xF, ID
// RL9: Repeated logs may overflow the record
// RL10: Collator out-of-range message logs 0x1c/0xF, ID
// RL11: Bad shared deactivate logs 0x1D/0xE, no data
// RL12: Locality or private deactivates are never reported
// RL13: Virtual SGI offline chip logs 0x25, chip/vector/vpe
// RL14: Virtual SGI unmapped logs 0x30/0xF, vector/vpe
// RL15: Virtual SGI inconsistent logs 0x33/0xF, vector/vpe
// RL16: Virtual pending read failure logs 0x34/0x12, vpe
// RL17: Misc data packed from bit 0, rest zero
// RL18: Whole record written in the detection cycle

// ------------------------------------------------------------
// Syndrome codes
// ------------------------------------------------------------
`define IES_SYN_REDIST      8'h12
`define IES_SYN_DIST        8'h13
`define IES_SYN_TRANS_OFF   8'h14
`define IES_SYN_BLOCK       8'h18
`define IES_SYN_ID_OOR      8'h19
`define IES_SYN_NO_TARGET   8'h1A
`define IES_SYN_ONE_OF_N    8'h1B
`define IES_SYN_COLLATOR    8'h1C
`define IES_SYN_DEACT       8'h1D
`define IES_SYN_VIRTUAL_SOFTWARE_INTERRUPT_OFF    8'h25
`define IES_SYN_VIRTUAL_SOFTWARE_INTERRUPT_UNMAP  8'h30
`define IES_SYN_VIRTUAL_SOFTWARE_INTERRUPT_INCON  8'h33
`define IES_SYN_VPT_READ    8'h34

// ------------------------------------------------------------
// Error type codes
// ------------------------------------------------------------
`define IES_ERROR_TYPE_CODE_CORRUPT    8'h06
`define IES_ERROR_TYPE_CODE_ILLEGAL    8'h0E
`define IES_ERROR_TYPE_CODE_STATE      8'h0F
`define IES_ERROR_TYPE_CODE_MEMRESP    8'h12

// ------------------------------------------------------------
// Widths
// ------------------------------------------------------------
`define IES_ADDR_W          32
`define IES_CHIP_W          4
`define IES_VPE_W           9
`define IES_NSRC            11

// ------------------------------------------------------------
// Register offsets, fields and reset values
// ------------------------------------------------------------
`define IES_OFS_REC         8'h00
`define IES_OFS_MISC        8'h04
`define IES_OFS_ADDR        8'h08
`define IES_OFS_IRQ_STAT    8'h0C
`define IES_OFS_IRQ_CLR     8'h10
`define IES_OFS_IRQ_EN      8'h14
`define IES_REC_VALID_BIT   0
`define IES_REC_OVF_BIT     1
`define IES_REC_ERROR_TYPE_CODE_LSB    8
`define IES_REC_SYN_LSB     16
`define IES_IRQ_LOG_BIT     0
`define IES_IRQ_OVF_BIT     1
`define IES_ZERO32          32'h0000_0000
`endif

// [inc/ies_pkg.sv]
`include "ies_consts.svh"
package ies_pkg;

  // Deactivate target classes
  typedef enum logic [1:0] {
    IES_DEACT_SHARED_MISSING  = 2'b00,
    IES_DEACT_SHARED_GROUP    = 2'b01,
    IES_DEACT_LOCALITY        = 2'b10,
    IES_DEACT_PRIVATE_MISSING = 2'b11
  } ies_deact_kind_e;

  // Virtual SGI failure classes; 2'b11 is illegal
  typedef enum logic [1:0] {
    IES_VIRTUAL_SOFTWARE_INTERRUPT_OFFLINE      = 2'b00,
    IES_VIRTUAL_SOFTWARE_INTERRUPT_UNMAPPED     = 2'b01,
    IES_VIRTUAL_SOFTWARE_INTERRUPT_INCONSISTENT = 2'b10
  } ies_virtual_software_interrupt_kind_e;

  typedef struct packed {
    logic                   valid;
    logic [`IES_ADDR_W-1:0] addr;
  } ies_addr_evt_s;

  typedef struct packed {
    logic       valid;
    logic [9:0] id;
  } ies_id_evt_s;

  typedef struct packed {
    logic            valid;
    ies_deact_kind_e kind;
  } ies_deact_evt_s;

  typedef struct packed {
    logic                  valid;
    ies_virtual_software_interrupt_kind_e        kind;
    logic [`IES_CHIP_W-1:0] chip;
    logic [15:0]           vector;
    logic [`IES_VPE_W-1:0] vpe;
  } ies_virtual_software_interrupt_evt_s;

  typedef struct packed {
    logic                  valid;
    logic [`IES_VPE_W-1:0] vpe;
  } ies_vpe_evt_s;

  typedef struct packed {
    logic [7:0]             syn;
    logic [7:0]             error_type_code;
    logic [31:0]            misc;
    logic [`IES_ADDR_W-1:0] addr;
  } ies_rec_s;

endpackage

// [sim/ies_syndrome_bench.sv]
`timescale 1ns/1ps
`include "ies_consts.svh"
module ies_syndrome_bench
  import ies_pkg::*;
;
  // ----------------------------------------
  // Stimulus and observation
  // ----------------------------------------
  logic        core_clk     = 1'b0;
  logic        rst_n        = 1'b0;
  logic        ce           = 1'b1;  // Dropped low only in t_silent, to check that an event is not taken
  logic [15:0] fire         = 16'h0000;  // One bit per event source and kind
  logic [7:0]  reg_addr     = 8'h00;
  logic [31:0] reg_wdata    = 32'h0000_0000;
  logic        reg_wr       = 1'b0;
  logic        reg_rd       = 1'b0;
  logic [31:0] reg_rdata;
  logic        irq;
  logic        rec_valid;
  int          miscompares  = 0;
  int          total_checks = 0;

  // Payloads with upper bits set where the record must drop them
  localparam logic [31:0] ADDR = 32'hCAFE_0124;
  localparam logic [9:0]  ID   = 10'h2A5;
  localparam logic [9:0]  BID  = 10'h3F5;
  localparam logic [3:0]  CHIP = 4'hA;
  localparam logic [15:0] VEC  = 16'h8421;
  localparam logic [8:0]  VPE  = 9'h1C3;

  always #50 core_clk = ~core_clk;

  // Bits 14 and 15 give the two deactivate kinds that must stay silent
  ies_syndrome u_ies_syndrome (
    .core_clk                  (core_clk),
    .rst_n                     (rst_n),
    .ce                        (ce),
    .redist_read_corrupt       (ies_addr_evt_s'{fire[0], ADDR}),
    .dist_read_corrupt         (ies_addr_evt_s'{fire[1], ADDR}),
    .translator_powered_off    (ies_addr_evt_s'{fire[2], ADDR}),
    .shared_block_missing      (ies_id_evt_s'{fire[3], BID}),
    .shared_id_out_of_range    (ies_id_evt_s'{fire[4], ID}),
    .shared_no_target          (ies_id_evt_s'{fire[5], ID}),
    .one_of_n_undeliverable    (ies_id_evt_s'{fire[6], ID}),
    .collator_out_of_range     (ies_id_evt_s'{fire[7], ID}),
    .bad_deactivate            (ies_deact_evt_s'{|{fire[15:14], fire[9:8]},
                                ies_deact_kind_e'({|fire[15:14], fire[15] | fire[9]})}),
    .virtual_sgi_fault         (ies_virtual_software_interrupt_evt_s'{|fire[12:10],
                                ies_virtual_software_interrupt_kind_e'({fire[12], fire[11]}), CHIP, VEC, VPE}),
    .virtual_pending_read_fail (ies_vpe_evt_s'{fire[13], VPE}),
    .reg_addr                  (reg_addr),
    .reg_wdata                 (reg_wdata),
    .reg_wr                    (reg_wr),
    .reg_rd                    (reg_rd),
    .reg_rdata                 (reg_rdata),
    .irq                       (irq),
    .rec_valid                 (rec_valid)
  );

  // ----------------------------------------
  // Expected record per source index
  // ----------------------------------------
  function automatic ies_rec_s expect_rec(int k);
    ies_rec_s r;
    case (k)
      0: r = '{8'h12, 8'h06, '0, ADDR};
      1: r = '{8'h13, 8'h06, '0, ADDR};
      2: r = '{8'h14, 8'h0F, '0, ADDR};
      3: r = '{8'h18, 8'h0E, {27'h0, BID[4:0]}, '0};
      4: r = '{8'h19, 8'h0E, {22'h0, ID}, '0};
      5: r = '{8'h1A, 8'h0F, {22'h0, ID}, '0};
      6: r = '{8'h1B, 8'h0F, {22'h0, ID}, '0};
      7: r = '{8'h1C, 8'h0F, {22'h0, ID}, '0};
      8, 9: r = '{8'h1D, 8'h0E, '0, '0};
      10: r = '{8'h25, 8'h0F, {3'h0, VPE, VEC, CHIP}, '0};
      11: r = '{8'h30, 8'h0F, {7'h0, VPE, VEC}, '0};
      12: r = '{8'h33, 8'h0F, {7'h0, VPE, VEC}, '0};
      default: r = '{8'h34, 8'h12, {23'h0, VPE}, '0};
    endcase
    return r;
  endfunction

  // ----------------------------------------
  // Shared bus and compare tasks
  // ----------------------------------------
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(logic [7:0] a, logic [31:0] exp);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd   <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask

  // One-cycle event pulse; returns just after the taking edge
  task automatic pulse(logic [15:0] m);
    @(posedge core_clk);
    fire <= m;
    @(posedge core_clk);
    fire <= 16'h0000;
    #1;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    rd(`IES_OFS_REC, 32'h0000_0000);
    rd(`IES_OFS_ADDR, 32'h0000_0000);
    rd(`IES_OFS_IRQ_EN, 32'h0000_0000);
    wr(8'h40, 32'hFFFF_FFFF);  // Unmapped write must be dropped
    rd(8'h40, 32'h0000_0000);
    rd(`IES_OFS_IRQ_STAT, 32'h0000_0000);
  endtask

  // Fires bits 0 to 13 in turn; bit 2 is a read of a powered-off translator
  task automatic t_records();
    ies_rec_s e;
    for (int k = 0; k < 14; k++)
    begin
      e = expect_rec(k);
      pulse(16'h0001 << k);
      chk({31'h0, rec_valid}, 32'h0000_0001);
      rd(`IES_OFS_REC, {8'h00, e.syn, e.error_type_code, 8'h01});
      rd(`IES_OFS_MISC, e.misc);
      rd(`IES_OFS_ADDR, e.addr);
      wr(`IES_OFS_REC, 32'h0000_0003);
      wr(`IES_OFS_IRQ_CLR, 32'h0000_0003);
    end
  endtask

  task automatic t_silent();
    pulse(16'h4000);
    pulse(16'h8000);
    chk({31'h0, rec_valid}, 32'h0000_0000);
    // Clock enable low: an event must not be taken
    @(posedge core_clk);
    ce <= 1'b0;
    pulse(16'h0001);
    ce <= 1'b1;
    chk({31'h0, rec_valid}, 32'h0000_0000);
    rd(`IES_OFS_IRQ_STAT, 32'h0000_0000);
  endtask

  // Two sources at once, then a repeat while full: first error kept
  task automatic t_overflow();
    pulse(16'h0060);
    pulse(16'h0001);
    rd(`IES_OFS_REC, 32'h001A_0F03);
    rd(`IES_OFS_MISC, {22'h0, ID});
    rd(`IES_OFS_IRQ_STAT, 32'h0000_0003);
    wr(`IES_OFS_REC, 32'h0000_0003);
    wr(`IES_OFS_IRQ_CLR, 32'h0000_0003);
    // Freeing the record drops valid and overflow; the codes stay readable
    rd(`IES_OFS_REC, 32'h001A_0F00);
  endtask

  // Raise, mask, unmask and clear the level output
  task automatic t_irq();
    wr(`IES_OFS_IRQ_EN, 32'h0000_0001);
    rd(`IES_OFS_IRQ_EN, 32'h0000_0001);
    rd(`IES_OFS_IRQ_CLR, 32'h0000_0000);  // Write-only place reads zero
    pulse(16'h0002);
    chk({31'h0, irq}, 32'h0000_0000);
    @(posedge core_clk);
    #1;
    chk({31'h0, irq}, 32'h0000_0001);
    wr(`IES_OFS_IRQ_EN, 32'h0000_0000);
    @(posedge core_clk);
    #1;
    chk({31'h0, irq}, 32'h0000_0000);
    wr(`IES_OFS_IRQ_EN, 32'h0000_0001);
    @(posedge core_clk);
    #1;
    chk({31'h0, irq}, 32'h0000_0001);
    wr(`IES_OFS_IRQ_CLR, 32'h0000_0001);
    wr(`IES_OFS_REC, 32'h0000_0001);
    @(posedge core_clk);
    #1;
    chk({31'h0, irq}, 32'h0000_0000);
    chk({31'h0, rec_valid}, 32'h0000_0000);
  endtask

  // ----------------------------------------
  // Verdict
  // ----------------------------------------
  task automatic conclude();
    if (miscompares == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial
  begin
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    t_reset();
    t_records();
    t_silent();
    t_overflow();
    t_irq();
    conclude();
  end
endmodule
